// File: inc/base_ctl_consts.svh
// Offsets, field positions, reset values and timing counts of the base control block.
// Assumes a 10 MHz i_ref_clk and long-word register offsets.
// Behaviour
// - Spare line direction and value from bits.
// - Clock-select line direction and value from bits.
// - Alive pulse is 10 ms or 1 ms.
// - Clock detect drives alive on missing reference.
// - Send-pulse bit emits one pulse, self-clears.
// - Alive direction bit sets line direction.
// - Each clock output gated by own enable.
// - Clock enable low stops operational clocks.
// - External select bit picks reference source.
// - Operational clock is reference over divisor+1.
// - Zero divisor with external: 1x clock.
// - Loop-test bit allows host FIFO read/write.
// - Load-levels redirects accesses, empty then full.
// - Load level at reset picks default offset.
// - Enable low holds FIFO in reset.
// - User switch enable shows DIP on FIFO A.
// - All control bits clear on reset.
// - Long-word offsets, base control at zero.
// - Alive input latch, cleared by status read.
// - Input line levels readable in status word.
`ifndef BASE_CTL_CONSTS_SVH
`define BASE_CTL_CONSTS_SVH
// Long-word register offsets.
`define OFS_BASE_CONTROL 6'h00
`define OFS_INPUT_STATUS 6'h05
// Base control word fields.
`define BCW_RESET 32'h0000_0000
`define BCW_MASK 32'h00ff_7ffd
`define B_SPARE_OUT 23
`define B_SPARE_DIR 22
`define B_CSEL_OUT 21
`define B_CSEL_DIR 20
`define B_PULSE_WIDE 19
`define B_CLK_DETECT 18
`define B_SEND_PULSE 17
`define B_ALIVE_DIR 16
`define B_XCLK2_EN 14
`define B_XCLK1_EN 13
`define B_CLK_EN 12
`define B_EXT_SEL 11
`define B_DIV_HI 10
`define B_DIV_LO 8
`define B_LOOP_B 7
`define B_LOOP_A 6
`define B_LOAD_B 5
`define B_FIFO_B_EN 4
`define B_LOAD_A 3
`define B_USER_SW 2
`define B_FIFO_A_EN 0
// Timing, in nanoseconds, and the clock period.
`define CLK_PERIOD_NS 100
`define ALIVE_SHORT_NS 1000000
`define ALIVE_LONG_NS 10000000
`define ALIVE_SHORT_CYC (`ALIVE_SHORT_NS / `CLK_PERIOD_NS)
`define ALIVE_LONG_CYC (`ALIVE_LONG_NS / `CLK_PERIOD_NS)
`define MISS_NS 3200
`define MISS_CYC (`MISS_NS / `CLK_PERIOD_NS)
`endif

// File: inc/base_ctl_pkg.sv
// Types of the base control block.
// Assumes the constants header is compiled alongside.
package base_ctl_pkg;
   // Whole state of the block, registered in one place.
   typedef struct packed {
      logic [31:0] ctl;        // Base control word.
      logic [31:0] rdata;      // Read data.
      logic [1:0] s_sp;        // Spare line synchroniser.
      logic [1:0] s_cs;        // Clock-select line synchroniser.
      logic [1:0] s_al;        // Alive line synchroniser.
      logic [2:0] s_osc;       // Oscillator synchroniser plus edge stage.
      logic [2:0] s_ext;       // External clock synchroniser plus edge stage.
      logic [7:0] s_sw0;       // DIP switch first stage.
      logic [7:0] s_sw1;       // DIP switch second stage.
      logic [16:0] pcnt;       // Alive pulse countdown.
      logic pulsing;           // Alive pulse in progress.
      logic [7:0] mcnt;        // Cycles since last external edge.
      logic missing;           // External clock missing.
      logic latch;             // Alive input latch.
      logic [2:0] dcnt;        // Divider position.
      logic [2:0] dcur;        // Divisor in force.
      logic src;               // Source in force.
      logic [2:0] gate;        // Enables in force: xclk2, xclk1, clk.
      logic op;                // Operational clock.
      logic x1;                // External clock 1 output.
      logic x2;                // External clock 2 output.
      logic [1:0] lvl_full;    // Next level register is almost full.
      logic [1:0] dflt63;      // Parallel programming caught at FIFO reset.
      logic [7:0] swv;         // DIP value for FIFO A reads.
      logic sp_o;              // Spare drive value.
      logic sp_oe_n;           // Spare output enable.
      logic cs_o;              // Clock-select drive value.
      logic cs_oe_n;           // Clock-select output enable.
      logic al_o;              // Alive drive value.
      logic al_oe_n;           // Alive output enable.
   } state_t;
endpackage : base_ctl_pkg

// File: rtl/base_ctl.sv
// Base control register and clock/discrete logic of the serial I/O board.
// Assumes a host access port on i_ref_clk and pin inputs from outside its domain.
`timescale 1ns/1ps
`default_nettype none
`include "base_ctl_consts.svh"
module base_ctl #(
   parameter int unsigned SHORT_CYC = `ALIVE_SHORT_CYC,
   parameter int unsigned LONG_CYC = `ALIVE_LONG_CYC,
   parameter int unsigned MISS_CYC = `MISS_CYC
) (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Host register access, long-word offsets.
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [5:0] i_addr,
   input wire logic [31:0] i_wdata,
   output logic [31:0] o_rdata,
   // Clock references and outputs.
   input wire logic i_osc_ref,
   input wire logic i_ext_ref,
   output logic o_op_clk,
   output logic o_xclk1,
   output logic o_xclk2,
   // Discrete lines, three signals each.
   input wire logic i_spare,
   output logic o_spare,
   output logic o_spare_oe_n,
   input wire logic i_csel,
   output logic o_csel,
   output logic o_csel_oe_n,
   input wire logic i_alive,
   output logic o_alive,
   output logic o_alive_oe_n,
   // External FIFO control; index 0 is FIFO A, 1 is FIFO B.
   input wire logic [1:0] i_fifo_acc,
   input wire logic [7:0] i_user_sw,
   output logic [1:0] o_fifo_rst_n,
   output logic [1:0] o_loop_test,
   output logic [1:0] o_load_lvl,
   output logic [1:0] o_lvl_full_sel,
   output logic [1:0] o_dflt_63,
   output logic o_sw_gate,
   output logic [7:0] o_sw_val
);
   import base_ctl_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   state_t st_ff;   // Registered state.
   state_t nxt_st;  // Next state.
   logic ref_rise;  // Reference rising edge in force.
   logic ext_rise;  // External clock rising edge.
   logic wrap;      // Divider period ends.
   logic st_rd;     // Status word read.
   logic [31:0] wv; // Masked write value.

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // All state advances here; synchronisers feed only their next stage.
   always_comb begin
      nxt_st = st_ff;
      wv = i_wdata & `BCW_MASK;
      // Shift pins in through two flops before any use.
      nxt_st.s_sp = {st_ff.s_sp[0], i_spare};
      nxt_st.s_cs = {st_ff.s_cs[0], i_csel};
      nxt_st.s_al = {st_ff.s_al[0], i_alive};
      nxt_st.s_osc = {st_ff.s_osc[1:0], i_osc_ref};
      nxt_st.s_ext = {st_ff.s_ext[1:0], i_ext_ref};
      nxt_st.s_sw0 = i_user_sw;
      nxt_st.s_sw1 = st_ff.s_sw0;
      ext_rise = st_ff.s_ext[1] & ~st_ff.s_ext[2];
      ref_rise = st_ff.src ? ext_rise : (st_ff.s_osc[1] & ~st_ff.s_osc[2]);
      st_rd = i_rd && (i_addr == `OFS_INPUT_STATUS);
      if (i_wr && (i_addr == `OFS_BASE_CONTROL)) begin
         nxt_st.ctl = wv;
      end
      // Missing reference: no edge for MISS_CYC cycles.
      // The count saturates, so a long loss never wraps back to present.
      if (ext_rise) begin
         nxt_st.mcnt = 8'h00;
      end else if (st_ff.mcnt != MISS_CYC[7:0]) begin
         nxt_st.mcnt = st_ff.mcnt + 8'h01;
      end
      nxt_st.missing = (st_ff.mcnt == MISS_CYC[7:0]);
      // one pulse per request, only when alive is an output.
      if (st_ff.pulsing) begin
         if (st_ff.pcnt == 17'h00000) begin
            nxt_st.pulsing = 1'b0;
            // send bit reads zero after pulse, unless rewritten.
            if (!(i_wr && (i_addr == `OFS_BASE_CONTROL))) begin
               nxt_st.ctl[`B_SEND_PULSE] = 1'b0;
            end
         end else begin
            nxt_st.pcnt = st_ff.pcnt - 17'h00001;
         end
      end else if (st_ff.ctl[`B_SEND_PULSE] && st_ff.ctl[`B_ALIVE_DIR]) begin
         nxt_st.pulsing = 1'b1;
         // Loaded one short: the loading edge is already the first high cycle.
         // width select
         nxt_st.pcnt = st_ff.ctl[`B_PULSE_WIDE] ? 17'(LONG_CYC - 1) : 17'(SHORT_CYC - 1);
      end
      // set wins over the read clear.
      if (st_rd) begin
         nxt_st.latch = 1'b0;
      end
      // Set terms: a high alive input, or a missing selected reference.
      if ((!st_ff.ctl[`B_ALIVE_DIR] && st_ff.s_al[1]) ||
          (st_ff.ctl[`B_CLK_DETECT] && st_ff.ctl[`B_EXT_SEL] && st_ff.missing)) begin
         nxt_st.latch = 1'b1;
      end
      // divide by divisor plus one; settings change at wrap, or at once while the external source is missing.
      // Counting reference edges keeps the period a whole number of them.
      wrap = ref_rise && (st_ff.dcnt == st_ff.dcur);
      if (ref_rise) begin
         nxt_st.dcnt = wrap ? 3'h0 : st_ff.dcnt + 3'h1;
      end
      // new source, divisor and gates take hold at a period boundary, or at once while the external source is missing.
      if (wrap || (st_ff.src && st_ff.missing)) begin
         nxt_st.dcur = st_ff.ctl[`B_DIV_HI:`B_DIV_LO];
         nxt_st.src = st_ff.ctl[`B_EXT_SEL];
         nxt_st.gate = st_ff.ctl[`B_XCLK2_EN:`B_CLK_EN];
         nxt_st.dcnt = 3'h0;
      end
      // zero divisor passes the reference through as a 1x clock.
      if (st_ff.dcur == 3'h0) begin
         nxt_st.op = st_ff.src ? st_ff.s_ext[1] : st_ff.s_osc[1];
      end else begin
         nxt_st.op = (nxt_st.dcnt <= {1'b0, st_ff.dcur[2:1]});
      end
      // Gate with the enables that hold after this edge, so that a stop or
      // a start lands on a period boundary and never leaves a runt pulse.
      // clock enable gates all clocks.
      nxt_st.op = nxt_st.op & nxt_st.gate[0];
      nxt_st.x1 = nxt_st.op & nxt_st.gate[1];
      nxt_st.x2 = nxt_st.op & nxt_st.gate[2];
      nxt_st.sp_o = st_ff.ctl[`B_SPARE_OUT];
      nxt_st.sp_oe_n = ~st_ff.ctl[`B_SPARE_DIR];
      nxt_st.cs_o = st_ff.ctl[`B_CSEL_OUT];
      nxt_st.cs_oe_n = ~st_ff.ctl[`B_CSEL_DIR];
      // alive high while selected reference is missing.
      nxt_st.al_o = st_ff.pulsing ||
         (st_ff.ctl[`B_CLK_DETECT] && st_ff.ctl[`B_EXT_SEL] && st_ff.missing);
      nxt_st.al_oe_n = ~st_ff.ctl[`B_ALIVE_DIR];
      // level accesses alternate, restart at empty on FIFO reset.
      // the load level is caught while the FIFO sits in reset.
      // FIFO A.
      if (!st_ff.ctl[`B_FIFO_A_EN]) begin
         nxt_st.lvl_full[0] = 1'b0;
         nxt_st.dflt63[0] = st_ff.ctl[`B_LOAD_A];
      end else if (i_fifo_acc[0] && st_ff.ctl[`B_LOAD_A]) begin
         nxt_st.lvl_full[0] = ~st_ff.lvl_full[0];
      end
      // FIFO B.
      if (!st_ff.ctl[`B_FIFO_B_EN]) begin
         nxt_st.lvl_full[1] = 1'b0;
         nxt_st.dflt63[1] = st_ff.ctl[`B_LOAD_B];
      end else if (i_fifo_acc[1] && st_ff.ctl[`B_LOAD_B]) begin
         nxt_st.lvl_full[1] = ~st_ff.lvl_full[1];
      end
      // DIP value offered while the gate is on.
      nxt_st.swv = st_ff.ctl[`B_USER_SW] ? st_ff.s_sw1 : 8'h00;
      // input levels and latch in the status word.
      // Without a read the last answer stands for the host to take.
      if (st_rd) begin
         // Latch, then alive, clock-select and spare levels.
         nxt_st.rdata = {28'h0000000, st_ff.latch, st_ff.s_al[1], st_ff.s_cs[1], st_ff.s_sp[1]};
      end else if (i_rd && (i_addr == `OFS_BASE_CONTROL)) begin
         // The control word in force: masked write, send bit cleared after its pulse.
         nxt_st.rdata = st_ff.ctl;
      end else if (i_rd) begin
         // Every other offset reads as zero.
         nxt_st.rdata = 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // everything clears on reset except the three output enables, which set.
   // Enables are active low, so every line leaves reset as an input.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         st_ff <= '0;
         st_ff.ctl <= `BCW_RESET;
         st_ff.sp_oe_n <= 1'b1;
         st_ff.cs_oe_n <= 1'b1;
         st_ff.al_oe_n <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flops.
   assign o_rdata = st_ff.rdata;
   assign o_op_clk = st_ff.op;
   assign o_xclk1 = st_ff.x1;
   assign o_xclk2 = st_ff.x2;
   assign o_spare = st_ff.sp_o;
   assign o_spare_oe_n = st_ff.sp_oe_n;
   assign o_csel = st_ff.cs_o;
   assign o_csel_oe_n = st_ff.cs_oe_n;
   assign o_alive = st_ff.al_o;
   assign o_alive_oe_n = st_ff.al_oe_n;
   // enable low holds the FIFO in reset.
   assign o_fifo_rst_n = {st_ff.ctl[`B_FIFO_B_EN], st_ff.ctl[`B_FIFO_A_EN]};
   // loop test to the FIFO port logic.
   assign o_loop_test = {st_ff.ctl[`B_LOOP_B], st_ff.ctl[`B_LOOP_A]};
   assign o_load_lvl = {st_ff.ctl[`B_LOAD_B], st_ff.ctl[`B_LOAD_A]};
   assign o_lvl_full_sel = st_ff.lvl_full;
   assign o_dflt_63 = st_ff.dflt63;
   assign o_sw_gate = st_ff.ctl[`B_USER_SW];
   assign o_sw_val = st_ff.swv;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   spare_drive_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $past(st_ff.ctl[`B_SPARE_DIR]) |-> !o_spare_oe_n && o_spare == $past(st_ff.ctl[`B_SPARE_OUT]))
      else $error("spare line not driven from its bits");
   csel_drive_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !$past(st_ff.ctl[`B_CSEL_DIR]) |-> o_csel_oe_n)
      else $error("clock-select line driven while input");
   pulse_len_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(st_ff.pulsing) |-> st_ff.pcnt ==
         ($past(st_ff.ctl[`B_PULSE_WIDE]) ? 17'(LONG_CYC - 1) : 17'(SHORT_CYC - 1)))
      else $error("alive pulse length wrong");
   send_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $fell(st_ff.pulsing) && !$past(i_wr) |-> !st_ff.ctl[`B_SEND_PULSE])
      else $error("send bit not cleared at pulse end");
   alive_dir_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ##1 o_alive_oe_n == !$past(st_ff.ctl[`B_ALIVE_DIR]))
      else $error("alive direction wrong");
   xclk_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (o_xclk1 |-> o_op_clk && st_ff.gate[1]) and (o_xclk2 |-> o_op_clk && st_ff.gate[2]))
      else $error("external clock not gated by its enable");
   clk_stop_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !st_ff.gate[0] ##1 !st_ff.gate[0] |-> !o_op_clk)
      else $error("operational clock runs while disabled");
   latch_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !st_ff.ctl[`B_ALIVE_DIR] && st_ff.s_al[1] |=> st_ff.latch)
      else $error("alive latch lost a high input");
   fifo_rst_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !st_ff.ctl[`B_FIFO_A_EN] |-> !o_fifo_rst_n[0] ##1 !o_lvl_full_sel[0])
      else $error("FIFO A not held in reset");
   // alive raised while the reference is lost.
   alive_miss_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $past(st_ff.ctl[`B_CLK_DETECT] && st_ff.ctl[`B_EXT_SEL] && st_ff.missing) |-> o_alive)
      else $error("alive not raised on a missing reference");
   // the divider never runs past its divisor.
   div_range_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      st_ff.dcnt <= st_ff.dcur)
      else $error("divider count beyond divisor");
   // a zero divisor passes the external clock through.
   pass_1x_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      st_ff.dcur == 3'h0 && st_ff.src && st_ff.gate[0] && !wrap && !st_ff.missing |=>
         o_op_clk == $past(st_ff.s_ext[1]))
      else $error("1x external clock not passed through");
   // the divided clock rises only at a period start.
   runt_free_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(o_op_clk) && $past(st_ff.dcur) != 3'h0 |-> st_ff.dcnt == 3'h0)
      else $error("operational clock rose inside a period");
   // each FIFO A level access moves to the other level register.
   level_step_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      o_fifo_rst_n[0] && o_load_lvl[0] && i_fifo_acc[0] |=>
         o_lvl_full_sel[0] != $past(o_lvl_full_sel[0]))
      else $error("level access did not alternate");
   // the load level is caught during FIFO B reset.
   dflt_catch_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !o_fifo_rst_n[1] |=> o_dflt_63[1] == $past(o_load_lvl[1]))
      else $error("default level not caught in reset");
   // the switch value is hidden while the gate is off.
   switch_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !o_sw_gate |=> o_sw_val == 8'h00)
      else $error("switch value shown while gated off");
   // a control read returns the word in force.
   ctl_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_rd && i_addr == `OFS_BASE_CONTROL |=> o_rdata == $past(st_ff.ctl))
      else $error("control read does not match the word");
   // a status read returns the input levels.
   status_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_rd && i_addr == `OFS_INPUT_STATUS |=>
         o_rdata[2:0] == $past({st_ff.s_al[1], st_ff.s_cs[1], st_ff.s_sp[1]}))
      else $error("status read does not show the line levels");
   // offsets outside the map read as zero.
   unmapped_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_rd && i_addr != `OFS_BASE_CONTROL && i_addr != `OFS_INPUT_STATUS |=>
         o_rdata == 32'h00000000)
      else $error("unmapped offset read not zero");
endmodule : base_ctl
`default_nettype wire

// File: tb/ext_equip.sv
// Far-side model: reference clocks and the far ends of the three discrete lines.
// Assumes the bench passes the design's drive values and enables in {alive, csel, spare} order.
`timescale 1ns/1ps
`default_nettype none
module ext_equip (
   // Bench controls.
   input wire logic i_ext_run,
   input wire logic [2:0] i_far,
   // Design side of the discrete lines.
   input wire logic [2:0] i_drv,
   input wire logic [2:0] i_oe_n,
   // Resolved lines and reference clocks.
   output logic [2:0] o_line,
   output logic o_osc,
   output logic o_ext
);
   // Onboard reference, 800 ns period, offset so it never meets a bench clock edge.
   initial begin
      o_osc = 1'b0;
      #33;
      forever #400 o_osc = ~o_osc;
   end
   // External reference, 1200 ns period; it stands low while stopped so loss shows.
   initial begin
      o_ext = 1'b0;
      forever #600 o_ext = i_ext_run ? ~o_ext : 1'b0;
   end
   // A line follows the design only while its enable is low, else the far end.
   assign o_line = (i_oe_n & i_far) | (~i_oe_n & i_drv);
endmodule : ext_equip
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the base control block.
// Assumes the far-side model and short alive counts of 20 and 50 cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import base_ctl_pkg::*;
   logic clk, rst_n, wr_s, rd_s, ext_run;
   logic [5:0] addr;
   logic [31:0] wdata;
   logic [1:0] acc;
   logic [7:0] sw;
   logic [2:0] far;
   wire [31:0] rdata;
   wire [2:0] drv, oe_n, line;
   wire [1:0] frst_n, loop, load, lsel, d63;
   wire [7:0] swv;
   wire op, x1, x2, osc, ext, swg;
   wire [3:0] mon = {drv[2], x2, x1, op};
   int num_errors = 0;
   int checks_done = 0;
   base_ctl #(.SHORT_CYC(20), .LONG_CYC(50), .MISS_CYC(32)) DUT (
      .i_ref_clk(clk), .i_rst_n(rst_n), .i_wr(wr_s), .i_rd(rd_s), .i_addr(addr),
      .i_wdata(wdata), .o_rdata(rdata), .i_osc_ref(osc), .i_ext_ref(ext),
      .o_op_clk(op), .o_xclk1(x1), .o_xclk2(x2),
      .i_spare(line[0]), .o_spare(drv[0]), .o_spare_oe_n(oe_n[0]),
      .i_csel(line[1]), .o_csel(drv[1]), .o_csel_oe_n(oe_n[1]),
      .i_alive(line[2]), .o_alive(drv[2]), .o_alive_oe_n(oe_n[2]),
      .i_fifo_acc(acc), .i_user_sw(sw), .o_fifo_rst_n(frst_n), .o_loop_test(loop),
      .o_load_lvl(load), .o_lvl_full_sel(lsel), .o_dflt_63(d63), .o_sw_gate(swg),
      .o_sw_val(swv));
   ext_equip far_end (.i_ext_run(ext_run), .i_far(far), .i_drv(drv), .i_oe_n(oe_n),
      .o_line(line), .o_osc(osc), .o_ext(ext));
   // Clock, 100 ns period.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // One comparison; a mismatch is reported and counted at once.
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // One-cycle write strobe.
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk) #1;
      wr_s = 1'b1; addr = a; wdata = d;
      @(posedge clk) #1;
      wr_s = 1'b0;
   endtask : wr
   // One-cycle read strobe; data is taken once the registered answer has settled.
   task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] e);
      @(posedge clk) #1;
      rd_s = 1'b1; addr = a;
      @(posedge clk) #1;
      rd_s = 1'b0;
      @(posedge clk) #1;
      chk(nm, rdata, e);
   endtask : rd_chk
   // Waits, bounded, for a rise of a monitored output, counting cycles.
   task automatic edge_up(input int i, inout int n);
      while (mon[i] !== 1'b0 && n < 2000) begin @(posedge clk) #1; n++; end
      while (mon[i] !== 1'b1 && n < 2000) begin @(posedge clk) #1; n++; end
   endtask : edge_up
   // Steady period; the first two rises are skipped since settings load at wrap.
   task automatic per_chk(input string nm, input int i, input int e);
      int n;
      n = 0;
      edge_up(i, n);
      edge_up(i, n);
      n = 0;
      edge_up(i, n);
      chk(nm, n, e);
   endtask : per_chk
   // Reset state of registers and pins.
   task automatic t_reset;
      rd_chk("ctl_reset", 6'h00, 32'h0000_0000);
      chk("oe_reset", oe_n, 3'b111);
      chk("fifo_reset", frst_n, 2'b00);
   endtask : t_reset
   // Register image, discrete outputs and FIFO control pins.
   task automatic t_regs;
      // FIFO A sits in reset before it is enabled.
      wr(6'h00, 32'h0000_0008);
      wr(6'h00, 32'hffd0_80cd);
      @(posedge clk) #1;
      @(posedge clk) #1;
      rd_chk("ctl_image", 6'h00, 32'h00d0_00cd);
      chk("lines_drv", {oe_n[1:0], drv[1:0]}, 4'b0001);
      chk("alive_in", oe_n[2], 1'b1);
      chk("fifo_en", frst_n, 2'b01);
      chk("loop_load", {loop, load}, 4'b1101);
      chk("dflt63", d63, 2'b01);
      chk("switch", {swg, swv}, {1'b1, sw});
      acc = 2'b01;
      @(posedge clk) #1;
      acc = 2'b00;
      chk("lvl_full", lsel, 2'b01);
      acc = 2'b01;
      @(posedge clk) #1;
      acc = 2'b00;
      chk("lvl_empty", lsel, 2'b00);
   endtask : t_regs
   // Input levels, alive latch and an unmapped read.
   task automatic t_inputs;
      wr(6'h00, 32'h0000_0000);
      far = 3'b011;
      repeat (4) @(posedge clk) #1;
      rd_chk("in_levels", 6'h05, 32'h0000_0003);
      chk("switch_off", {swg, swv}, 9'h000);
      far = 3'b100;
      repeat (4) @(posedge clk) #1;
      rd_chk("latch_hold", 6'h05, 32'h0000_000c);
      far = 3'b000;
      repeat (4) @(posedge clk) #1;
      rd_chk("latch_set", 6'h05, 32'h0000_0008);
      rd_chk("latch_clr", 6'h05, 32'h0000_0000);
      rd_chk("unmapped", 6'h3f, 32'h0000_0000);
   endtask : t_inputs
   // Short and long alive pulses with self-clearing send bit.
   task automatic t_alive;
      int n;
      wr(6'h00, 32'h0003_0000);
      edge_up(3, n);
      n = 0;
      while (mon[3] === 1'b1 && n < 2000) begin @(posedge clk) #1; n++; end
      chk("pulse_short", n, 20);
      rd_chk("send_clear", 6'h00, 32'h0001_0000);
      wr(6'h00, 32'h000b_0000);
      edge_up(3, n);
      n = 0;
      while (mon[3] === 1'b1 && n < 2000) begin @(posedge clk) #1; n++; end
      chk("pulse_long", n, 50);
   endtask : t_alive
   // Divider, source select, output gating and missing-clock alarm.
   task automatic t_clocks;
      wr(6'h00, 32'h0000_3100);
      per_chk("op_div1", 0, 16);
      per_chk("x1_div1", 1, 16);
      chk("x2_off", x2, 1'b0);
      wr(6'h00, 32'h0000_5100);
      per_chk("x2_div1", 2, 16);
      chk("x1_off", x1, 1'b0);
      wr(6'h00, 32'h0000_3200);
      per_chk("op_div2", 0, 24);
      wr(6'h00, 32'h0000_3900);
      per_chk("op_ext", 0, 24);
      wr(6'h00, 32'h0000_3800);
      per_chk("op_1x", 0, 12);
      wr(6'h00, 32'h0000_0900);
      repeat (40) @(posedge clk) #1;
      repeat (48) begin
         @(posedge clk) #1;
         chk("clk_off", {op, x1, x2}, 3'b000);
      end
      wr(6'h00, 32'h0005_3900);
      ext_run = 1'b0;
      repeat (60) @(posedge clk) #1;
      chk("miss_alive", {oe_n[2], drv[2]}, 2'b01);
      ext_run = 1'b1;
      repeat (60) @(posedge clk) #1;
      chk("found_alive", drv[2], 1'b0);
   endtask : t_clocks
   // Verdict; the single place where the run ends.
   task automatic test_done;
      $display("Checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   // Main sequence after 20 cycles of reset.
   initial begin
      rst_n = 1'b0; wr_s = 1'b0; rd_s = 1'b0; addr = 6'h00; wdata = 32'h0;
      acc = 2'b00; sw = 8'h3c; far = 3'b000; ext_run = 1'b1;
      repeat (20) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_regs();
      t_inputs();
      t_alive();
      t_clocks();
      test_done();
   end
   // Watchdog well beyond the expected run length.
   initial begin
      #3000000;
      num_errors++;
      test_done();
   end
endmodule : testbench
`default_nettype wire
